// file: rtl/fegs_cfg.svh
// Offsets, field positions, reset values and timing counts of the guard
`ifndef FEGS_CFG_SVH
`define FEGS_CFG_SVH

// Bus geometry
`define FEGS_ADDR_W 8
`define FEGS_DATA_W 32
`define FEGS_STRB_W 4

// Register byte offsets
`define FEGS_OFF_CTRL 8'h00
`define FEGS_OFF_IRQ_STATUS 8'h04
`define FEGS_OFF_IRQ_MASK 8'h08

// Control/status field positions
`define FEGS_CTRL_ERR_BIT 4
`define FEGS_CTRL_DL_BIT 0
`define FEGS_CTRL_FIXED 8'h80
`define FEGS_CTRL_RESET 8'h80

// Interrupt status and mask layout
`define FEGS_IRQ_W 2
`define FEGS_IRQ_ERR_BIT 0
`define FEGS_IRQ_DL_BIT 1
`define FEGS_IRQ_MASK_RESET 2'h0

// Unlock key value that allows a routine download
`define FEGS_UNLOCK_KEY 8'ha5

// Bus responses
`define FEGS_RESP_OKAY 2'h0
`define FEGS_RESP_SLVERR 2'h2

// Reset hold after an error, in microseconds, and in core cycles
`define FEGS_CLK_MHZ 20
`define FEGS_RESET_HOLD_US 100
`define FEGS_RESET_HOLD_CYC (`FEGS_RESET_HOLD_US * `FEGS_CLK_MHZ)

`endif

// file: rtl/fegs_pkg.sv
// State types of the flash error guard
`include "fegs_cfg.svh"

package fegs_pkg;

    // Register file and guard state of the core
    typedef struct packed {
        logic err_flag;
        logic err_pulse;
        logic dl_req;
        logic [`FEGS_IRQ_W-1:0] irq_status;
        logic [`FEGS_IRQ_W-1:0] irq_mask;
        logic irq;
    } fegs_core_state_type;

    // Channel state of the bus slave
    typedef struct packed {
        logic aw_held;
        logic [`FEGS_ADDR_W-1:0] awaddr;
        logic w_held;
        logic [`FEGS_DATA_W-1:0] wdata;
        logic [`FEGS_STRB_W-1:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [`FEGS_DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } fegs_slave_state_type;

endpackage

// file: rtl/fegs_reg_if.sv
// Register access carrier between the bus slave and the guard core
`timescale 1ns/1ps
`include "fegs_cfg.svh"

interface fegs_reg_if;
    // Write strobe with its address and data
    logic wr_en;
    logic [`FEGS_ADDR_W-1:0] wr_addr;
    logic [`FEGS_DATA_W-1:0] wr_data;
    logic [`FEGS_STRB_W-1:0] wr_strb;
    logic wr_ok;
    // Read strobe with its address and data
    logic rd_en;
    logic [`FEGS_ADDR_W-1:0] rd_addr;
    logic [`FEGS_DATA_W-1:0] rd_data;
    logic rd_ok;

    // Bus side issues strobes
    modport slave_mp (
        output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
        input wr_ok, rd_data, rd_ok
    );
    // Core side answers them
    modport core_mp (
        input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
        output wr_ok, rd_data, rd_ok
    );
endinterface

// file: rtl/fegs_axil_slave.sv
// AXI4-Lite slave that turns bus transfers into register strobes
`timescale 1ns/1ps
`include "fegs_cfg.svh"

module fegs_axil_slave (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    // Write address and data
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [`FEGS_ADDR_W-1:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [`FEGS_DATA_W-1:0] i_wdata,
    input wire logic [`FEGS_STRB_W-1:0] i_wstrb,
    // Write response
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // Read address and data
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [`FEGS_ADDR_W-1:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [`FEGS_DATA_W-1:0] o_rdata,
    output logic [1:0] o_rresp,
    // Register strobes
    fegs_reg_if.slave_mp reg_port
);

    fegs_pkg::fegs_slave_state_type st_reg; // Registered channel state
    fegs_pkg::fegs_slave_state_type st_next; // Next channel state

    // Each write half accepts only while neither its own half nor a response is parked; reads while no read data is parked
    assign o_awready = !st_reg.aw_held && !st_reg.bvalid;
    assign o_wready = !st_reg.w_held && !st_reg.bvalid;
    assign o_arready = !st_reg.rvalid;
    assign o_bvalid = st_reg.bvalid;
    assign o_bresp = st_reg.bresp;
    assign o_rvalid = st_reg.rvalid;
    assign o_rdata = st_reg.rdata;
    assign o_rresp = st_reg.rresp;

    // Write fires once both halves are parked, read fires on its handshake
    assign reg_port.wr_en = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;
    assign reg_port.wr_addr = st_reg.awaddr;
    assign reg_port.wr_data = st_reg.wdata;
    assign reg_port.wr_strb = st_reg.wstrb;
    assign reg_port.rd_en = i_arvalid && !st_reg.rvalid;
    assign reg_port.rd_addr = i_araddr;

    // Next state of all five channels
    always_comb
    begin
        st_next = st_reg;
        // Park the halves in whatever order they come
        if (i_awvalid && o_awready)
        begin
            st_next.aw_held = 1'h1;
            st_next.awaddr = i_awaddr;
        end
        if (i_wvalid && o_wready)
        begin
            st_next.w_held = 1'h1;
            st_next.wdata = i_wdata;
            st_next.wstrb = i_wstrb;
        end
        // Commit and answer
        if (reg_port.wr_en)
        begin
            st_next.aw_held = 1'h0;
            st_next.w_held = 1'h0;
            st_next.bvalid = 1'h1;
            st_next.bresp = reg_port.wr_ok ? `FEGS_RESP_OKAY
                                           : `FEGS_RESP_SLVERR;
        end
        else if (st_reg.bvalid && i_bready)
        begin
            st_next.bvalid = 1'h0;
        end
        // Read data is captured so it holds while the master stalls
        if (reg_port.rd_en)
        begin
            st_next.rvalid = 1'h1;
            st_next.rdata = reg_port.rd_data;
            st_next.rresp = reg_port.rd_ok ? `FEGS_RESP_OKAY
                                           : `FEGS_RESP_SLVERR;
        end
        else if (st_reg.rvalid && i_rready)
        begin
            st_next.rvalid = 1'h0;
        end
    end

    // State register
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

endmodule // fegs_axil_slave

// file: rtl/fegs_top.sv
// Flash error guard: control/status register, error protection, download
`timescale 1ns/1ps
`include "fegs_cfg.svh"

// Notes on behaviour
// - Eight-bit control and status register exists
// - Reserved bits fixed: bit7 one, others zero
// - Bit 4 reads the sticky error flag
// - Error flag blocks all programming and erasing
// - Flag clears only on power-on reset
// - Interrupt taken while busy sets the flag
// - Flash read while busy sets the flag
// - Sleep or standby while busy sets flag
// - Foreign bus master while busy sets flag
// - Bit 0 requests routine copy into RAM
// - Request bit reads zero, clears when done
// - Request needs no overlay, key, RAM code
module fegs_top (
    // Clock and power-on reset
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    // Write address channel
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [`FEGS_ADDR_W-1:0] i_awaddr,
    // Write data channel
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [`FEGS_DATA_W-1:0] i_wdata,
    input wire logic [`FEGS_STRB_W-1:0] i_wstrb,
    // Write response channel
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // Read address channel
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [`FEGS_ADDR_W-1:0] i_araddr,
    // Read data channel
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [`FEGS_DATA_W-1:0] o_rdata,
    output logic [1:0] o_rresp,
    // Activity monitors from the core and bus arbiter
    input wire logic i_prog_erase_busy,
    input wire logic i_irq_taken,
    input wire logic i_flash_read,
    input wire logic i_sleep_exec,
    input wire logic i_alt_master_grant,
    // Download qualifiers and completion
    input wire logic i_ram_overlay_active,
    input wire logic [7:0] i_flash_unlock_key,
    input wire logic i_write_from_ram,
    input wire logic i_download_done,
    // Guard outputs
    output logic o_error_protect,
    output logic o_prog_erase_permit,
    output logic o_error_event,
    output logic o_download_request,
    output logic o_irq
);

    fegs_pkg::fegs_core_state_type st_reg; // Registered guard state
    fegs_pkg::fegs_core_state_type st_next; // Next guard state
    fegs_reg_if reg_bus(); // Strobes from the bus slave
    logic violation; // Illegal activity during an operation
    logic ctrl_wr; // Byte 0 write to the control register
    logic dl_accept; // Download request meets every condition
    logic dl_finish; // Copy into RAM has just completed
    logic [7:0] ctrl_view; // Control register as software sees it

    // True when a byte address selects a given register word
    function automatic logic fegs_hit(
        input logic [`FEGS_ADDR_W-1:0] addr,
        input logic [`FEGS_ADDR_W-1:0] off
    );
        fegs_hit = (addr[`FEGS_ADDR_W-1:2] == off[`FEGS_ADDR_W-1:2]);
    endfunction

    // True when an address maps to any register
    function automatic logic fegs_mapped(
        input logic [`FEGS_ADDR_W-1:0] addr
    );
        fegs_mapped = fegs_hit(addr, `FEGS_OFF_CTRL)
            || fegs_hit(addr, `FEGS_OFF_IRQ_STATUS)
            || fegs_hit(addr, `FEGS_OFF_IRQ_MASK);
    endfunction

    // Bus slave, kept apart so channel timing is in one place
    fegs_axil_slave u_slave (
        .i_core_clk(i_core_clk),
        .i_arst_n(i_arst_n),
        .i_awvalid(i_awvalid),
        .o_awready(o_awready),
        .i_awaddr(i_awaddr),
        .i_wvalid(i_wvalid),
        .o_wready(o_wready),
        .i_wdata(i_wdata),
        .i_wstrb(i_wstrb),
        .o_bvalid(o_bvalid),
        .i_bready(i_bready),
        .o_bresp(o_bresp),
        .i_arvalid(i_arvalid),
        .o_arready(o_arready),
        .i_araddr(i_araddr),
        .o_rvalid(o_rvalid),
        .i_rready(i_rready),
        .o_rdata(o_rdata),
        .o_rresp(o_rresp),
        .reg_port(reg_bus.slave_mp)
    );

    // Error sources; each only counts while an operation is running
    always_comb
    begin
        violation = 1'h0;
        if (i_prog_erase_busy)
        begin
            if (i_irq_taken)
                violation = 1'h1;
            if (i_flash_read)
                violation = 1'h1;
            if (i_sleep_exec)
                violation = 1'h1;
            if (i_alt_master_grant)
                violation = 1'h1;
        end
    end

    assign ctrl_wr = reg_bus.wr_en && reg_bus.wr_strb[0]
        && fegs_hit(reg_bus.wr_addr, `FEGS_OFF_CTRL);

    assign dl_accept = ctrl_wr
        && reg_bus.wr_data[`FEGS_CTRL_DL_BIT]
        && !i_ram_overlay_active
        && (i_flash_unlock_key == `FEGS_UNLOCK_KEY)
        && i_write_from_ram;
    assign dl_finish = st_reg.dl_req && i_download_done;

    always_comb
    begin
        ctrl_view = `FEGS_CTRL_FIXED;
        ctrl_view[`FEGS_CTRL_ERR_BIT] = st_reg.err_flag;
        ctrl_view[`FEGS_CTRL_DL_BIT] = 1'h0;
    end

    // Read mux and address check for the slave
    always_comb
    begin
        reg_bus.rd_data = '0;
        reg_bus.rd_ok = fegs_mapped(reg_bus.rd_addr);
        reg_bus.wr_ok = fegs_mapped(reg_bus.wr_addr);
        if (fegs_hit(reg_bus.rd_addr, `FEGS_OFF_CTRL))
            reg_bus.rd_data[7:0] = ctrl_view;
        else if (fegs_hit(reg_bus.rd_addr, `FEGS_OFF_IRQ_STATUS))
            reg_bus.rd_data[`FEGS_IRQ_W-1:0] = st_reg.irq_status;
        else if (fegs_hit(reg_bus.rd_addr, `FEGS_OFF_IRQ_MASK))
            reg_bus.rd_data[`FEGS_IRQ_W-1:0] = st_reg.irq_mask;
        else
            reg_bus.rd_data = '0;
    end

    // Next state of the guard
    always_comb
    begin
        st_next = st_reg;
        // flag is sticky
        // Writes never touch it, so only the reset brings it back
        if (violation)
            st_next.err_flag = 1'h1;
        st_next.err_pulse = violation && !st_reg.err_flag;
        if (dl_finish)
            st_next.dl_req = 1'h0;
        // software sets request
        // A fresh accept wins over a completion in the same cycle
        if (dl_accept)
            st_next.dl_req = 1'h1;
        // Reading the status word clears it; new events still land
        if (reg_bus.rd_en && fegs_hit(reg_bus.rd_addr, `FEGS_OFF_IRQ_STATUS))
            st_next.irq_status = '0;
        if (st_next.err_pulse)
            st_next.irq_status[`FEGS_IRQ_ERR_BIT] = 1'h1;
        if (dl_finish)
            st_next.irq_status[`FEGS_IRQ_DL_BIT] = 1'h1;
        // Mask takes byte 0 only
        if (reg_bus.wr_en && reg_bus.wr_strb[0]
            && fegs_hit(reg_bus.wr_addr, `FEGS_OFF_IRQ_MASK))
            st_next.irq_mask = reg_bus.wr_data[`FEGS_IRQ_W-1:0];
        // Registered so the line has no glitch from the mux
        st_next.irq = |(st_next.irq_status & st_next.irq_mask);
    end

    // reset length is external
    // The power-on clear is the only way out of protection, and the
    // driver of it must keep it low long enough for the array to settle.
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            st_reg <= '0;
            st_reg.irq_mask <= `FEGS_IRQ_MASK_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign o_error_protect = st_reg.err_flag;
    assign o_prog_erase_permit = !st_reg.err_flag;
    assign o_error_event = st_reg.err_pulse;
    assign o_download_request = st_reg.dl_req;
    assign o_irq = st_reg.irq;

    // Checks on the guard's own behaviour
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_arst_n);

    ctrl_read_fixed_a:
    assert property (reg_bus.rd_en && fegs_hit(reg_bus.rd_addr,
        `FEGS_OFF_CTRL) |=> o_rvalid && o_rdata[7:5] == 3'h4
        && o_rdata[3:0] == 4'h0 && o_rdata[4] == $past(st_reg.err_flag))
    else $error("control register readback wrong");

    err_sticky_a:
    assert property (st_reg.err_flag |=> st_reg.err_flag [*8])
    else $error("error flag dropped without reset");

    err_irq_set_a:
    assert property (i_prog_erase_busy && i_irq_taken
        |=> o_error_protect && !o_prog_erase_permit)
    else $error("interrupt during operation not flagged");

    err_read_set_a:
    assert property (i_prog_erase_busy && i_flash_read |=> st_reg.err_flag)
    else $error("flash read during operation not flagged");

    err_sleep_set_a:
    assert property (i_prog_erase_busy && i_sleep_exec |=> st_reg.err_flag)
    else $error("sleep during operation not flagged");

    err_master_set_a:
    assert property (i_prog_erase_busy && i_alt_master_grant
        |=> st_reg.err_flag)
    else $error("foreign master during operation not flagged");

    err_cause_only_a:
    assert property ($rose(st_reg.err_flag) |-> $past(violation))
    else $error("error flag rose without a cause");

    err_pulse_once_a:
    assert property ($rose(o_error_protect) |-> o_error_event
        ##1 !o_error_event [*8])
    else $error("error pulse not a single cycle");

    dl_gate_a:
    assert property ($rose(o_download_request) |-> $past(dl_accept))
    else $error("download started without its conditions");

    dl_clear_a:
    assert property (o_download_request && i_download_done && !dl_accept
        |=> !o_download_request)
    else $error("download request not cleared on completion");

    irq_level_a:
    assert property (st_reg.err_pulse && st_reg.irq_mask[0] |-> o_irq)
    else $error("unmasked error did not raise interrupt");

    // Permit is always the inverse of protection, so no cycle exists
    // in which an operation is allowed while the array is protected
    // permit tracks protection
    permit_inverse_a:
    assert property (o_prog_erase_permit == !o_error_protect)
    else $error("permit and protection disagree");

    // An event pulse only ever comes with the flag it announces
    // pulse implies flag
    event_with_flag_a:
    assert property (o_error_event |-> o_error_protect)
    else $error("error event without the flag");

    // Software writes of any value leave the flag alone
    // write keeps flag
    write_keeps_flag_a:
    assert property (st_reg.err_flag && reg_bus.wr_en |=> o_error_protect)
    else $error("write cleared the error flag");

    // Monitors only count while an operation runs; idle noise is harmless
    // idle activity ignored
    idle_quiet_a:
    assert property (!i_prog_erase_busy && !st_reg.err_flag
        |=> !o_error_event && !o_error_protect)
    else $error("idle activity raised the flag");

    // A write that misses any qualifier must not start a copy
    // locked write refused
    dl_locked_a:
    assert property (!o_download_request && ctrl_wr
        && (i_ram_overlay_active || !i_write_from_ram
        || i_flash_unlock_key != `FEGS_UNLOCK_KEY)
        |=> !o_download_request)
    else $error("locked write started a download");

    // The request stays up until the copy reports completion
    // request held until done
    dl_stays_a:
    assert property (o_download_request && !i_download_done
        |=> o_download_request)
    else $error("download request dropped early");

    // Register reads are answered on the very next cycle
    // read answered promptly
    read_answer_a:
    assert property (reg_bus.rd_en |=> o_rvalid)
    else $error("register read not answered");

    // A committed write is answered on the very next cycle
    // write answered promptly
    write_answer_a:
    assert property (reg_bus.wr_en |=> o_bvalid)
    else $error("register write not answered");

    err_seen_c: cover property ($rose(o_error_protect));
    dl_cycle_c: cover property ($rose(o_download_request)
        ##[1:50] $fell(o_download_request));
    irq_read_c: cover property (o_irq ##[1:20] !o_irq);
    bad_addr_c: cover property (o_rvalid && o_rresp == `FEGS_RESP_SLVERR);
    locked_write_c: cover property (ctrl_wr && !dl_accept);

endmodule // fegs_top

// file: testbench/fegs_cpu_model.sv
// Behavioural model of the CPU core and bus masters around the guard
`timescale 1ns/1ps
`include "fegs_cfg.svh"

module fegs_cpu_model (
    // Clock
    input wire logic i_core_clk,
    // Download request seen from the guard
    input wire logic i_download_request,
    // Activity monitors: irq, flash read, sleep, foreign master
    output logic o_busy,
    output logic [3:0] o_activity,
    // Download qualifiers and completion
    output logic o_overlay,
    output logic [7:0] o_key,
    output logic o_from_ram,
    output logic o_done
);
    int dl_delay = 2; // Copy length in cycles; bench makes it prompt or slow
    int cnt = 0; // Cycles since the request rose

    // Quiet start: no activity, download locked
    initial
    begin
        o_busy = 1'b0;
        o_activity = 4'h0;
        o_overlay = 1'b1;
        o_key = 8'h00;
        o_from_ram = 1'b0;
        o_done = 1'b0;
    end

    // Program or erase in progress
    task automatic set_busy(input logic b);
        o_busy <= b;
    endtask

    // One cycle of activity of kind k
    task automatic strike(input int k);
        o_activity[k] <= 1'b1;
        @(posedge i_core_clk);
        o_activity[k] <= 1'b0;
    endtask

    task automatic unlock(input logic on);
        o_overlay <= ~on;
        o_key <= on ? `FEGS_UNLOCK_KEY : 8'h5a;
        o_from_ram <= on;
    endtask

    always @(posedge i_core_clk)
    begin
        cnt <= i_download_request ? cnt + 1 : 0;
        o_done <= i_download_request && cnt == dl_delay && !o_done;
    end
endmodule // fegs_cpu_model

// file: testbench/flash_error_guard_status_test.sv
// Self-checking bench of the flash error guard
`timescale 1ns/1ps
`include "fegs_cfg.svh"

`define CHK(got, exp) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) \
        begin \
            n_fail++; \
            $display("Error t=%0t got %h exp %h", $time, got, exp); \
        end \
    end

module flash_error_guard_status_test;
    // Clock, reset and bus
    logic i_core_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [`FEGS_ADDR_W-1:0] awaddr = 8'h00, araddr = 8'h00;
    logic [`FEGS_DATA_W-1:0] wdata = 32'h0, rdata;
    logic [1:0] bresp, rresp;
    // Model side and guard outputs
    logic busy, overlay, from_ram, dl_done;
    logic [3:0] act;
    logic [7:0] key;
    logic o_error_protect, o_prog_erase_permit, o_error_event;
    logic o_download_request, o_irq;
    int n_fail = 0, n_tests = 0, n_ev = 0;

    always #25 i_core_clk = ~i_core_clk;

    // Count event pulses; checked only while events are quiet
    always @(posedge i_core_clk)
        if (o_error_event === 1'b1)
            n_ev++;

    fegs_top dut (
        .i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
        .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
        .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
        .i_wstrb(4'h1), .o_bvalid(bvalid), .i_bready(bready),
        .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready),
        .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready),
        .o_rdata(rdata), .o_rresp(rresp), .i_prog_erase_busy(busy),
        .i_irq_taken(act[0]), .i_flash_read(act[1]),
        .i_sleep_exec(act[2]), .i_alt_master_grant(act[3]),
        .i_ram_overlay_active(overlay), .i_flash_unlock_key(key),
        .i_write_from_ram(from_ram), .i_download_done(dl_done),
        .o_error_protect(o_error_protect),
        .o_prog_erase_permit(o_prog_erase_permit),
        .o_error_event(o_error_event),
        .o_download_request(o_download_request), .o_irq(o_irq)
    );

    fegs_cpu_model cpu (
        .i_core_clk(i_core_clk), .i_download_request(o_download_request),
        .o_busy(busy), .o_activity(act), .o_overlay(overlay), .o_key(key),
        .o_from_ram(from_ram), .o_done(dl_done)
    );

    // Report counts and end the run
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Hold reset n cycles, then release
    task automatic por(input int n);
        i_arst_n <= 1'b0;
        repeat (n) @(posedge i_core_clk);
        i_arst_n <= 1'b1;
        @(posedge i_core_clk);
    endtask

    // Write one word; address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge i_core_clk);
            n++;
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
        end while (!(bvalid && bready) && n < 64);
        r = bresp;
        bready <= 1'b0;
        if (n >= 64)
            n_fail++;
    endtask

    // Read one word and compare data and response
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                          input logic [1:0] er);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge i_core_clk);
            n++;
            if (arvalid && arready)
                arvalid <= 1'b0;
        end while (!(rvalid && rready) && n < 64);
        rready <= 1'b0;
        if (n >= 64)
            n_fail++;
        `CHK(rdata, e)
        `CHK(rresp, er)
    endtask

    // Main sequence
    initial
    begin
        logic [1:0] r;
        int n0;
        por(8);
        `CHK(o_error_protect, 1'b0)
        `CHK(o_prog_erase_permit, 1'b1)
        rd_chk(`FEGS_OFF_CTRL, 32'h80, `FEGS_RESP_OKAY);
        rd_chk(`FEGS_OFF_IRQ_MASK, 32'h0, `FEGS_RESP_OKAY);
        // Locked: all ones reach only fixed bits and a refused request
        wr(`FEGS_OFF_CTRL, 32'hff, r);
        `CHK(o_download_request, 1'b0)
        rd_chk(`FEGS_OFF_CTRL, 32'h80, `FEGS_RESP_OKAY);
        wr(8'h0c, 32'h1, r);
        `CHK(r, `FEGS_RESP_SLVERR)
        rd_chk(8'h0c, 32'h0, `FEGS_RESP_SLVERR);
        wr(`FEGS_OFF_IRQ_MASK, 32'hff, r);
        rd_chk(`FEGS_OFF_IRQ_MASK, 32'h3, `FEGS_RESP_OKAY);
        $display("test registers done");
        // Activity while idle must be ignored
        for (int k = 0; k < 4; k++)
            cpu.strike(k);
        repeat (2) @(posedge i_core_clk);
        `CHK(o_error_protect, 1'b0)
        $display("test idle activity done");
        // Download with a prompt and a slow copy
        cpu.unlock(1'b1);
        for (int i = 0; i < 2; i++)
        begin
            cpu.dl_delay = i ? 12 : 1;
            wr(`FEGS_OFF_CTRL, 32'h01, r);
            `CHK(o_download_request, 1'b1)
            rd_chk(`FEGS_OFF_CTRL, 32'h80, `FEGS_RESP_OKAY);
            rd_chk(`FEGS_OFF_CTRL, 32'h80, `FEGS_RESP_OKAY);
            for (int n = 0; n < 64 && o_download_request !== 1'b0; n++)
                @(posedge i_core_clk);
            repeat (2) @(posedge i_core_clk);
            `CHK(o_download_request, 1'b0)
            `CHK(o_irq, 1'b1)
            rd_chk(`FEGS_OFF_IRQ_STATUS, 32'h2, `FEGS_RESP_OKAY);
            @(posedge i_core_clk);
            `CHK(o_irq, 1'b0)
        end
        cpu.unlock(1'b0);
        $display("test download done");
        // Each kind of activity while busy sets the sticky flag
        for (int k = 0; k < 4; k++)
        begin
            n0 = n_ev;
            cpu.set_busy(1'b1);
            cpu.strike(k);
            cpu.set_busy(1'b0);
            @(posedge i_core_clk);
            `CHK(o_error_protect, 1'b1)
            `CHK(o_prog_erase_permit, 1'b0)
            wr(`FEGS_OFF_IRQ_MASK, 32'h1, r);
            wr(`FEGS_OFF_CTRL, 32'h0, r);
            rd_chk(`FEGS_OFF_CTRL, 32'h90, `FEGS_RESP_OKAY);
            `CHK(o_prog_erase_permit, 1'b0)
            `CHK(n_ev - n0, 1)
            `CHK(o_irq, 1'b1)
            rd_chk(`FEGS_OFF_IRQ_STATUS, 32'h1, `FEGS_RESP_OKAY);
            por(`FEGS_RESET_HOLD_CYC);
            `CHK(o_error_protect, 1'b0)
            rd_chk(`FEGS_OFF_CTRL, 32'h80, `FEGS_RESP_OKAY);
        end
        $display("test error flag done");
        print_verdict();
    end

    // Watchdog well beyond the expected run
    initial
    begin
        #2000000;
        n_fail++;
        print_verdict();
    end
endmodule // flash_error_guard_status_test
